// ---- hw/scb_defines.svh ----
`ifndef SCB_DEFINES_SVH
`define SCB_DEFINES_SVH

// spi frame: write flag, 9-bit address, 16-bit data, msb first
`define SCB_ADDR_W 9
`define SCB_DATA_W 16
`define SCB_FRAME_BITS 26
`define SCB_SCLK_HALF 4

// timing
`define SCB_CLK_PERIOD_NS 50
`define SCB_RST_WAIT_US 10
`define SCB_RST_WAIT_CYC ((`SCB_RST_WAIT_US * 1000 + `SCB_CLK_PERIOD_NS - 1) / `SCB_CLK_PERIOD_NS)
`define SCB_CLK_STABLE_NS 2000
`define SCB_CLK_STABLE_CYC ((`SCB_CLK_STABLE_NS + `SCB_CLK_PERIOD_NS - 1) / `SCB_CLK_PERIOD_NS)
`define SCB_POLL_MAX 16'h00FF

// register offsets in the sensor
`define SCB_REG_VARIANT 9'h002
`define SCB_REG_PLL_SRST 9'h008
`define SCB_REG_CGEN_SRST 9'h009
`define SCB_REG_PLL_EN 9'h010
`define SCB_REG_PLL_CFG 9'h011
`define SCB_REG_CLK_IN 9'h014
`define SCB_REG_LOCK_A 9'h01A
`define SCB_REG_LOCK_B 9'h01B
`define SCB_REG_CLK_MGMT 9'h020
`define SCB_REG_LOGIC_EN 9'h022
`define SCB_REG_LOCK_STAT 9'h018
`define SCB_LOCK_BIT 0

// data values
`define SCB_D_ZERO 16'h0000
`define SCB_D_ONE 16'h0001
`define SCB_D_PAR_BASE 16'h0002
`define SCB_D_CM1_S8_PLL 16'h200C
`define SCB_D_CM1_S10_PLL 16'h2004
`define SCB_D_CM1_S8_LV 16'h2008
`define SCB_D_CM1_S10_LV 16'h2000
`define SCB_D_PLL_S8 16'h210F
`define SCB_D_PLL_S10 16'h2113
`define SCB_D_LKA_S8 16'h1180
`define SCB_D_LKA_S10 16'h2280
`define SCB_D_LKB_S8 16'hCCBC
`define SCB_D_LKB_S10 16'h3D2D
`define SCB_D_PLL_ON 16'h0003
`define SCB_D_PLL_BYP 16'h0007
`define SCB_D_CM2_8P 16'h200E
`define SCB_D_CM2_8L 16'h200A
`define SCB_D_CM2_10P 16'h2006
`define SCB_D_CM2_10L 16'h2002

`endif

// ---- hw/scb_loader.sv ----
// Function
// - start sensor input clock only after supplies report settled.
// - release sensor reset only after input clock is stable.
// - wait 10 us after reset release before first spi write.
// - input clock is pll reference, or lvds pair in serial modes without pll.
// - first clock phase written in fixed order, values per mode and pll use.
// - serial modes without pll keep lvds clock running.
// - serial modes with pll poll lock flag and continue only when set.
// - parallel mode or no pll never polls the lock flag.
// - first write goes to variant register, value by mode and colour.
// - serial 8-bit with pll first phase value set.
// - serial 10-bit with pll first phase value set.
// - serial without pll writes clock management then lvds input enable.
// - parallel mode writes clock management, input select, pll bypass.
// - second phase releases clock generator, sets logic clock, enables logic.
// - second phase logic clock value chosen by mode and pll use.
// - second phase writes issued strictly in order.
`timescale 1ns/1ps
`include "scb_defines.svh"

module scb_loader (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic start,
    input wire scb_pkg::scb_cfg_t cfg,
    input wire logic supplies_ok,
    input wire logic spi_miso,
    output logic spi_sclk,
    output logic spi_mosi,
    output logic spi_cs_n,
    output logic clk_run,
    output logic clk_sel_lvds,
    output logic sensor_reset_n,
    output logic busy,
    output logic done,
    output logic lock_fail
);

    localparam int RST_WAIT_CYC = `SCB_RST_WAIT_CYC;

    scb_pkg::scb_state_t state_q, state_d;
    scb_pkg::scb_cfg_t cfg_q;
    scb_pkg::scb_step_t step;
    logic [1:0] sup_sync_q, miso_sync_q;
    logic [15:0] wait_q, poll_q;
    logic [3:0] idx_q;
    logic issued_q;
    logic clk_run_q, clk_sel_lvds_q, rst_n_q, busy_q, done_q, fail_q;
    logic xfer_act_q, xfer_done_q, sclk_q, mosi_q, cs_n_q;
    logic [2:0] div_q;
    logic [4:0] bit_q;
    logic [25:0] shreg_q;
    logic [15:0] rx_q;
    logic tick, in_xfer_state, xfer_go, need_poll, lock_ok, step_last;

    // step table: address and data for each phase, mode and step index
    function automatic scb_pkg::scb_step_t step_f(input scb_pkg::scb_cfg_t c,
                                                  input logic ph2,
                                                  input logic [3:0] i);
        scb_pkg::scb_step_t s;
        logic s8;
        logic par;
        logic pll;
        s8 = (c.mode == scb_pkg::MODE_S8);
        par = (c.mode == scb_pkg::MODE_PAR);
        pll = c.use_pll && !par;
        s = '{addr: `SCB_REG_VARIANT, data: `SCB_D_ZERO, last: 1'b0};
        if (ph2)
        begin
            case (i)
                4'h0: s = '{addr: `SCB_REG_CGEN_SRST, data: `SCB_D_ZERO, last: 1'b0};
                4'h1: s = '{addr: `SCB_REG_CLK_MGMT,
                            data: (par || (s8 && pll)) ? `SCB_D_CM2_8P :
                                  s8 ? `SCB_D_CM2_8L : pll ? `SCB_D_CM2_10P : `SCB_D_CM2_10L,
                            last: 1'b0};
                default: s = '{addr: `SCB_REG_LOGIC_EN, data: `SCB_D_ONE, last: 1'b1};
            endcase
        end
        else if (i == 4'h0)
        begin
            s.data = (par ? `SCB_D_PAR_BASE : `SCB_D_ZERO) | {15'h0000, c.color};
        end
        else if (par)
        begin
            case (i)
                4'h1: s = '{addr: `SCB_REG_CLK_MGMT, data: `SCB_D_CM1_S8_PLL, last: 1'b0};
                4'h2: s = '{addr: `SCB_REG_CLK_IN, data: `SCB_D_ZERO, last: 1'b0};
                default: s = '{addr: `SCB_REG_PLL_EN, data: `SCB_D_PLL_BYP, last: 1'b1};
            endcase
        end
        else if (!pll)
        begin
            case (i)
                4'h1: s = '{addr: `SCB_REG_CLK_MGMT,
                            data: s8 ? `SCB_D_CM1_S8_LV : `SCB_D_CM1_S10_LV, last: 1'b0};
                default: s = '{addr: `SCB_REG_CLK_IN, data: `SCB_D_ONE, last: 1'b1};
            endcase
        end
        else
        begin
            case (i)
                4'h1: s = '{addr: `SCB_REG_CLK_MGMT,
                            data: s8 ? `SCB_D_CM1_S8_PLL : `SCB_D_CM1_S10_PLL, last: 1'b0};
                4'h2: s = '{addr: `SCB_REG_CLK_IN, data: `SCB_D_ZERO, last: 1'b0};
                4'h3: s = '{addr: `SCB_REG_PLL_CFG,
                            data: s8 ? `SCB_D_PLL_S8 : `SCB_D_PLL_S10, last: 1'b0};
                4'h4: s = '{addr: `SCB_REG_LOCK_A,
                            data: s8 ? `SCB_D_LKA_S8 : `SCB_D_LKA_S10, last: 1'b0};
                4'h5: s = '{addr: `SCB_REG_LOCK_B,
                            data: s8 ? `SCB_D_LKB_S8 : `SCB_D_LKB_S10, last: 1'b0};
                4'h6: s = '{addr: `SCB_REG_PLL_SRST, data: `SCB_D_ZERO, last: 1'b0};
                default: s = '{addr: `SCB_REG_PLL_EN, data: `SCB_D_PLL_ON, last: 1'b1};
            endcase
        end
        return s;
    endfunction : step_f

    // decode of current step and handshake terms
    assign step = step_f(cfg_q, state_q == scb_pkg::ST_P2, idx_q);
    assign step_last = step.last;
    assign in_xfer_state = (state_q == scb_pkg::ST_P1) || (state_q == scb_pkg::ST_LOCK)
                           || (state_q == scb_pkg::ST_P2);
    assign xfer_go = in_xfer_state && !issued_q;
    assign need_poll = cfg_q.use_pll && (cfg_q.mode != scb_pkg::MODE_PAR);
    assign lock_ok = rx_q[`SCB_LOCK_BIT];
    assign tick = xfer_act_q && (div_q == 3'(`SCB_SCLK_HALF - 1));

    // two-flop synchronisers for the supplies_ok and spi_miso pins from outside
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sup_sync_q <= 2'h0;
            miso_sync_q <= 2'h0;
        end
        else
        begin
            sup_sync_q <= {sup_sync_q[0], supplies_ok};
            miso_sync_q <= {miso_sync_q[0], spi_miso};
        end
    end

    // bring-up sequencer next state
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            scb_pkg::ST_IDLE: if (start && sup_sync_q[1]) state_d = scb_pkg::ST_CLK;
            scb_pkg::ST_CLK: if (wait_q == 16'(`SCB_CLK_STABLE_CYC)) state_d = scb_pkg::ST_RST;
            scb_pkg::ST_RST: if (wait_q == 16'(RST_WAIT_CYC)) state_d = scb_pkg::ST_P1;
            scb_pkg::ST_P1:
                if (xfer_done_q && step_last)
                    state_d = need_poll ? scb_pkg::ST_LOCK : scb_pkg::ST_P2;
            scb_pkg::ST_LOCK:
                if (xfer_done_q && lock_ok)
                    state_d = scb_pkg::ST_P2;
                else if (xfer_done_q && poll_q == `SCB_POLL_MAX)
                    state_d = scb_pkg::ST_FAIL;
            scb_pkg::ST_P2: if (xfer_done_q && step_last) state_d = scb_pkg::ST_DONE;
            scb_pkg::ST_DONE: if (start) state_d = scb_pkg::ST_IDLE;
            scb_pkg::ST_FAIL: if (start) state_d = scb_pkg::ST_IDLE;
            default: state_d = scb_pkg::ST_IDLE;
        endcase
    end

    // sequencer registers
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_q <= scb_pkg::ST_IDLE;
            cfg_q <= '{mode: scb_pkg::MODE_S8, use_pll: 1'b0, color: 1'b0};
            wait_q <= 16'h0000;
            poll_q <= 16'h0000;
            idx_q <= 4'h0;
            issued_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            if (state_q == scb_pkg::ST_IDLE)
                cfg_q <= cfg;
            wait_q <= (state_d != state_q) ? 16'h0000 : wait_q + 16'h0001;
            if (state_d != state_q || xfer_done_q)
                issued_q <= 1'b0;
            else if (xfer_go)
                issued_q <= 1'b1;
            // one step at a time, strictly in table order
            if (state_d != state_q)
                idx_q <= 4'h0;
            else if (xfer_done_q && state_q != scb_pkg::ST_LOCK)
                idx_q <= idx_q + 4'h1;
            if (state_q != scb_pkg::ST_LOCK)
                poll_q <= 16'h0000;
            else if (xfer_done_q)
                poll_q <= poll_q + 16'h0001;
        end
    end

    // sensor clock, reset and status pins
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            clk_run_q <= 1'b0;
            clk_sel_lvds_q <= 1'b0;
            rst_n_q <= 1'b0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            fail_q <= 1'b0;
        end
        else
        begin
            if (state_q == scb_pkg::ST_IDLE)
            begin
                clk_run_q <= state_d == scb_pkg::ST_CLK;
                clk_sel_lvds_q <= !cfg.use_pll && cfg.mode != scb_pkg::MODE_PAR;
            end
            rst_n_q <= state_q != scb_pkg::ST_IDLE && state_q != scb_pkg::ST_CLK;
            busy_q <= in_xfer_state || state_q == scb_pkg::ST_CLK || state_q == scb_pkg::ST_RST;
            done_q <= state_d == scb_pkg::ST_DONE;
            fail_q <= state_d == scb_pkg::ST_FAIL;
        end
    end

    // spi shifter: sclk idles low, data changes on falling edge
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            xfer_act_q <= 1'b0;
            xfer_done_q <= 1'b0;
            sclk_q <= 1'b0;
            mosi_q <= 1'b0;
            cs_n_q <= 1'b1;
            div_q <= 3'h0;
            bit_q <= 5'h00;
            shreg_q <= 26'h0000000;
            rx_q <= 16'h0000;
        end
        else
        begin
            xfer_done_q <= 1'b0;
            div_q <= (xfer_go || tick) ? 3'h0 : div_q + 3'h1;
            if (xfer_go)
            begin
                xfer_act_q <= 1'b1;
                cs_n_q <= 1'b0;
                bit_q <= 5'h00;
                shreg_q <= (state_q == scb_pkg::ST_LOCK) ?
                           {1'b0, `SCB_REG_LOCK_STAT, 16'h0000} :
                           {1'b1, step.addr, step.data};
                mosi_q <= state_q != scb_pkg::ST_LOCK;
            end
            else if (tick && !sclk_q)
                sclk_q <= 1'b1;
            else if (tick)
            begin
                sclk_q <= 1'b0;
                rx_q <= {rx_q[14:0], miso_sync_q[1]};
                if (bit_q == 5'(`SCB_FRAME_BITS - 1))
                begin
                    xfer_act_q <= 1'b0;
                    cs_n_q <= 1'b1;
                    xfer_done_q <= 1'b1;
                end
                else
                begin
                    bit_q <= bit_q + 5'h01;
                    shreg_q <= {shreg_q[24:0], 1'b0};
                    mosi_q <= shreg_q[24];
                end
            end
        end
    end

    // outputs straight from flip-flops
    assign spi_sclk = sclk_q;
    assign spi_mosi = mosi_q;
    assign spi_cs_n = cs_n_q;
    assign clk_run = clk_run_q;
    assign clk_sel_lvds = clk_sel_lvds_q;
    assign sensor_reset_n = rst_n_q;
    assign busy = busy_q;
    assign done = done_q;
    assign lock_fail = fail_q;

    // helper: cycles since sensor reset release, saturating
    logic [15:0] since_rst_q;
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            since_rst_q <= 16'h0000;
        else if (!rst_n_q)
            since_rst_q <= 16'h0000;
        else if (since_rst_q != 16'hFFFF)
            since_rst_q <= since_rst_q + 16'h0001;
    end

    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    clk_after_supply_a: assert property ($rose(clk_run_q) |-> sup_sync_q[1])
        else $error("sensor clock started before supplies settled");
    rst_after_clk_a: assert property ($rose(rst_n_q) |-> clk_run_q && $past(clk_run_q, 8))
        else $error("reset released before clock was stable");
    spi_wait_a: assert property ($fell(cs_n_q) |-> since_rst_q >= RST_WAIT_CYC)
        else $error("spi access too soon after reset release");
    lvds_source_a: assert property (clk_run_q && !cfg_q.use_pll && cfg_q.mode != scb_pkg::MODE_PAR
                                    |-> clk_sel_lvds_q)
        else $error("lvds clock not selected in serial mode without pll");
    first_addr_a: assert property ($fell(cs_n_q) && state_q == scb_pkg::ST_P1 && idx_q == 4'h0
                                   |-> shreg_q[24:16] == `SCB_REG_VARIANT)
        else $error("first write not to variant register");
    poll_skip_a: assert property (state_q == scb_pkg::ST_LOCK |-> need_poll)
        else $error("lock flag polled without pll");
    lock_gate_a: assert property ($past(state_q) == scb_pkg::ST_LOCK && state_q == scb_pkg::ST_P2
                                  |-> lock_ok)
        else $error("second phase entered without lock");
    step_order_a: assert property ($changed(idx_q) && idx_q != 4'h0
                                   |-> idx_q == $past(idx_q) + 4'h1)
        else $error("clock phase step skipped");
    done_after_p2_a: assert property ($rose(done_q) |-> $past(state_q, 2) == scb_pkg::ST_P2)
        else $error("done raised before final write");
    frame_low_a: assert property ($fell(cs_n_q) |-> !cs_n_q [*8])
        else $error("spi frame cut short");

    cov_pll_done: cover property (state_q == scb_pkg::ST_LOCK ##[1:1000] done_q);
    cov_par_done: cover property (cfg_q.mode == scb_pkg::MODE_PAR && $rose(done_q));
    cov_lvds_done: cover property (clk_sel_lvds_q && $rose(done_q));
    cov_fail: cover property ($rose(fail_q));

endmodule : scb_loader

// ---- hw/scb_pkg.sv ----
package scb_pkg;

    typedef enum logic [1:0] {
        MODE_S8 = 2'h0,
        MODE_S10 = 2'h1,
        MODE_PAR = 2'h2
    } scb_mode_t;

    typedef enum logic [7:0] {
        ST_IDLE = 8'h01,
        ST_CLK = 8'h02,
        ST_RST = 8'h04,
        ST_P1 = 8'h08,
        ST_LOCK = 8'h10,
        ST_P2 = 8'h20,
        ST_DONE = 8'h40,
        ST_FAIL = 8'h80
    } scb_state_t;

    typedef struct packed {
        scb_mode_t mode;
        logic use_pll;
        logic color;
    } scb_cfg_t;

    typedef struct packed {
        logic [8:0] addr;
        logic [15:0] data;
        logic last;
    } scb_step_t;

endpackage : scb_pkg

// ---- sim/scb_sensor_model.sv ----
`timescale 1ns/1ps

module scb_sensor_model (
    input wire logic spi_sclk,
    input wire logic spi_mosi,
    input wire logic spi_cs_n,
    input wire logic clk_run,
    input wire logic clk_sel_lvds,
    input wire logic sensor_reset_n,
    input wire logic [15:0] polls_to_lock,
    output logic spi_miso,
    output logic [25:0] frame,
    output logic frame_stb,
    output logic fault
);
    logic [15:0] regs [0:63];
    logic [25:0] sh;
    logic [15:0] rd_word;
    logic in_frame;
    int nbits;
    int rd_count;
    realtime t_clk;
    realtime t_rel;
    // only clocking registers may be touched before the logic blocks run
    function automatic logic clk_reg(input logic [8:0] a);
        return a inside {9'h002, 9'h008, 9'h009, 9'h010, 9'h011, 9'h014,
            9'h018, 9'h01A, 9'h01B, 9'h020, 9'h022};
    endfunction : clk_reg
    // power-on state of the model's own flags
    initial
    begin
        spi_miso = 1'b0;
        frame = 26'h0000000;
        frame_stb = 1'b0;
        fault = 1'b0;
        in_frame = 1'b0;
    end
    // sensor reset clears the register file and the poll count
    always @(negedge sensor_reset_n)
    begin
        for (int i = 0; i < 64; i++)
            regs[i] = 16'h0000;
        rd_count = 0;
    end
    always @(posedge clk_run)
        t_clk = $realtime;
    // reset may leave only once the input clock has run and settled
    always @(posedge sensor_reset_n)
    begin
        t_rel = $realtime;
        if (!clk_run || t_rel - t_clk < 2000.0)
            fault = 1'b1;
    end
    // a frame may start only 10 us after reset release
    always @(negedge spi_cs_n)
    begin
        in_frame = 1'b1;
        nbits = 0;
        if (!sensor_reset_n || $realtime - t_rel < 10000.0)
            fault = 1'b1;
    end
    // sensor takes mosi on the rising sclk
    always @(posedge spi_sclk)
        if (in_frame)
        begin
            sh = {sh[24:0], spi_mosi};
            nbits = nbits + 1;
        end
    // read data leaves msb first after the address, lock flag in bit 0
    always @(negedge spi_sclk)
        if (in_frame && nbits >= 10 && nbits < 26)
        begin
            if (nbits == 10)
                rd_word = (sh[8:0] == 9'h018) ? {15'h0000, regs[16] == 16'h0003 &&
                    rd_count >= int'(polls_to_lock)} : regs[sh[5:0]];
            spi_miso = rd_word[25 - nbits];
        end
    // end of frame: apply it, check access limits and clock source
    always @(posedge spi_cs_n)
        if (in_frame)
        begin
            in_frame = 1'b0;
            spi_miso = ~spi_miso;
            frame = sh;
            if (nbits != 26)
                fault = 1'b1;
            if (regs[34][0] !== 1'b1 && !clk_reg(sh[24:16]))
                fault = 1'b1;
            if (sh[25])
                regs[sh[21:16]] = sh[15:0];
            else if (sh[24:16] == 9'h018)
            begin
                if (regs[2][1])
                    fault = 1'b1;
                rd_count = rd_count + 1;
            end
            if (!clk_run || (regs[20][0] && !clk_sel_lvds) || (regs[2][1] && clk_sel_lvds))
                fault = 1'b1;
            frame_stb = ~frame_stb;
        end
endmodule : scb_sensor_model

// ---- sim/testbench.sv ----
`timescale 1ns/1ps

module testbench;
    logic ref_clk, arst_n, start, supplies_ok, spi_miso, spi_sclk, spi_mosi, spi_cs_n;
    logic clk_run, clk_sel_lvds, sensor_reset_n, busy, done, lock_fail, frame_stb, fault;
    scb_pkg::scb_cfg_t cfg;
    logic [15:0] polls_to_lock;
    logic [25:0] frame;
    logic [25:0] e;
    logic [25:0] exp_q [$];
    int n_mismatch, checks, cycles;
    scb_loader i_scb_loader (.ref_clk(ref_clk), .arst_n(arst_n), .start(start), .cfg(cfg),
        .supplies_ok(supplies_ok), .spi_miso(spi_miso), .spi_sclk(spi_sclk),
        .spi_mosi(spi_mosi), .spi_cs_n(spi_cs_n), .clk_run(clk_run),
        .clk_sel_lvds(clk_sel_lvds), .sensor_reset_n(sensor_reset_n), .busy(busy),
        .done(done), .lock_fail(lock_fail));
    scb_sensor_model i_scb_sensor_model (.spi_sclk(spi_sclk), .spi_mosi(spi_mosi),
        .spi_cs_n(spi_cs_n), .clk_run(clk_run), .clk_sel_lvds(clk_sel_lvds),
        .sensor_reset_n(sensor_reset_n), .polls_to_lock(polls_to_lock), .spi_miso(spi_miso),
        .frame(frame), .frame_stb(frame_stb), .fault(fault));
    task print_verdict;
        if (n_mismatch == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : print_verdict
    task automatic check(input logic [25:0] got, input logic [25:0] want);
        checks++;
        if (got !== want)
        begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, want);
        end
    endtask : check
    function automatic void push(input logic wr, input logic [8:0] a, input logic [15:0] d);
        exp_q.push_back({wr, a, d});
    endfunction : push
    // expected frame list for one mode; reads carry no data to compare
    function automatic void load_exp(input scb_pkg::scb_mode_t m, input logic lp,
        input logic col, input int nrd, input logic p2);
        logic s8;
        logic par;
        s8 = (m == scb_pkg::MODE_S8);
        par = (m == scb_pkg::MODE_PAR);
        exp_q.delete();
        push(1'b1, 9'h002, {14'h0000, par, col});
        if (par)
        begin
            push(1'b1, 9'h020, 16'h200C);
            push(1'b1, 9'h014, 16'h0000);
            push(1'b1, 9'h010, 16'h0007);
        end
        else if (lp)
        begin
            push(1'b1, 9'h020, s8 ? 16'h200C : 16'h2004);
            push(1'b1, 9'h014, 16'h0000);
            push(1'b1, 9'h011, s8 ? 16'h210F : 16'h2113);
            push(1'b1, 9'h01A, s8 ? 16'h1180 : 16'h2280);
            push(1'b1, 9'h01B, s8 ? 16'hCCBC : 16'h3D2D);
            push(1'b1, 9'h008, 16'h0000);
            push(1'b1, 9'h010, 16'h0003);
            for (int i = 0; i < nrd; i++)
                push(1'b0, 9'h018, 16'h0000);
        end
        else
        begin
            push(1'b1, 9'h020, s8 ? 16'h2008 : 16'h2000);
            push(1'b1, 9'h014, 16'h0001);
        end
        if (p2)
        begin
            push(1'b1, 9'h009, 16'h0000);
            push(1'b1, 9'h020, (par || (s8 && lp)) ? 16'h200E :
                s8 ? 16'h200A : lp ? 16'h2006 : 16'h2002);
            push(1'b1, 9'h022, 16'h0001);
        end
    endfunction : load_exp
    // one bring-up from a fresh reset; cfg is disturbed once the start is taken
    task automatic run(input scb_pkg::scb_mode_t m, input logic pll, input logic col,
        input int polls, input logic fail);
        int t;
        logic par;
        logic [25:0] g;
        logic [25:0] w;
        par = (m == scb_pkg::MODE_PAR);
        arst_n = 1'b0;
        repeat (2) @(negedge ref_clk);
        arst_n = 1'b1;
        polls_to_lock = fail ? 16'hFFFF : 16'(polls);
        load_exp(m, pll && !par, col, fail ? 256 : polls + 1, !fail); // sequencer gives up on poll 256
        cfg = '{mode: m, use_pll: pll, color: col};
        repeat (3) @(negedge ref_clk);
        start = 1'b1;
        @(negedge ref_clk);
        start = 1'b0;
        cfg = '{mode: par ? scb_pkg::MODE_S8 : scb_pkg::MODE_PAR, use_pll: !pll, color: !col};
        @(negedge ref_clk);
        check({23'h000000, clk_run, busy, sensor_reset_n}, 26'h0000006);
        t = 0;
        while (done !== 1'b1 && lock_fail !== 1'b1 && t < 60000)
        begin
            @(negedge ref_clk);
            t++;
        end
        g = {20'h00000, done, lock_fail, clk_run, clk_sel_lvds, sensor_reset_n, fault};
        w = {20'h00000, !fail, fail, 1'b1, !par && !pll, 1'b1, 1'b0};
        check(g, w);
        check(26'(exp_q.size()), 26'h0000000);
        start = 1'b1;
        @(negedge ref_clk);
        start = 1'b0;
        repeat (3) @(negedge ref_clk);
        check({23'h000000, done, busy, lock_fail}, 26'h0000000);
    endtask : run
    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    // each finished frame is compared with the next expected one
    always @(frame_stb)
        if (arst_n === 1'b1 && $time > 0)
        begin
            if (exp_q.size() == 0)
                check(frame, 26'h3FFFFFF);
            else
            begin
                e = exp_q.pop_front();
                check(e[25] ? frame : {frame[25:16], 16'h0000}, e);
            end
            check({25'h0000000, done}, 26'h0000000);
        end
    // hang guard
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 100000)
        begin
            n_mismatch++;
            print_verdict();
        end
    end
    // main sequence: supplies held low first, then every mode, then a lock that never comes
    initial
    begin
        arst_n = 1'b1;
        start = 1'b0;
        supplies_ok = 1'b0;
        cfg = '{mode: scb_pkg::MODE_S8, use_pll: 1'b0, color: 1'b0};
        polls_to_lock = 16'h0000;
        #5 arst_n = 1'b0;
        repeat (6) @(negedge ref_clk);
        arst_n = 1'b1;
        start = 1'b1;
        repeat (30) @(negedge ref_clk);
        check({24'h000000, clk_run, busy}, 26'h0000000);
        supplies_ok = 1'b1;
        start = 1'b0;
        run(scb_pkg::MODE_S8, 1'b1, 1'b0, 2, 1'b0);
        run(scb_pkg::MODE_S8, 1'b0, 1'b1, 0, 1'b0);
        run(scb_pkg::MODE_S10, 1'b1, 1'b1, 0, 1'b0);
        run(scb_pkg::MODE_S10, 1'b0, 1'b0, 0, 1'b0);
        run(scb_pkg::MODE_PAR, 1'b1, 1'b0, 0, 1'b0);
        run(scb_pkg::MODE_PAR, 1'b0, 1'b1, 0, 1'b0);
        run(scb_pkg::MODE_S10, 1'b1, 1'b0, 0, 1'b1);
        print_verdict();
    end
endmodule : testbench
